// File: rtl/free_list_ctrl.sv
// buffer free-list controller: two bank free heads, free block count
`timescale 1ns/1ps
`default_nettype none
`include "buf_free_map.svh"

module free_list_ctrl (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // host register bus
  input wire logic [15:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_rd_valid_out,
  // configuration
  input wire logic memory_type_select_in,
  // allocation request from the forwarding side
  input wire logic alloc_req_in,
  input wire logic alloc_bank_in,
  output logic alloc_grant_out,
  output logic alloc_refused_out,
  output logic [`ID_WIDTH-1:0] alloc_id_out,
  output logic [`SRAM_ADDR_WIDTH-1:0] alloc_sram_addr_out,
  // release request from output port control
  input wire logic release_req_in,
  input wire logic [`ID_WIDTH-1:0] release_id_in,
  output logic release_ack_out,
  // status
  output logic lists_ready_out
);

  // ***************************************************************
  // state
  // ***************************************************************
  free_list_pkg::pop_state_t state;
  free_list_pkg::buf_id_t head [0:1];
  logic [`ID_WIDTH-1:0] free_count;
  logic [`ID_WIDTH-1:0] locked_count;
  logic [`EPOCH_WIDTH-1:0] epoch;
  logic pop_bank;
  free_list_pkg::buf_id_t pop_id;

  link_mem_if lm ();

  link_mem mem_inst (
    .clk_in(clk_in),
    .port(lm)
  );

  // ***************************************************************
  // host decode
  // ***************************************************************
  logic wr_count_lo;
  logic wr_count_mid;
  logic wr_count_hi;
  logic wr_clear;
  logic rd_count_lo;

  assign wr_count_lo = host_wr_in &&
    host_addr_in == `REG_BASE + `FREE_COUNT_OFS;
  assign wr_count_mid = host_wr_in &&
    host_addr_in == `REG_BASE + `FREE_COUNT_OFS + 16'h0001;
  assign wr_count_hi = host_wr_in &&
    host_addr_in == `REG_BASE + `FREE_COUNT_OFS + 16'h0002;
  assign wr_clear = host_wr_in &&
    host_addr_in == `REG_BASE + `CLEAR_PTRS_OFS;
  assign rd_count_lo = host_rd_in &&
    host_addr_in == `REG_BASE + `FREE_COUNT_OFS;

  // ***************************************************************
  // request acceptance
  // ***************************************************************
  logic take_release;
  logic take_alloc;
  logic alloc_ok;

  // a held request is not taken again in the cycle its answer shows
  assign take_release = state == free_list_pkg::ST_IDLE && !wr_clear &&
    release_req_in && !release_ack_out;
  assign take_alloc = state == free_list_pkg::ST_IDLE && !wr_clear &&
    !take_release && alloc_req_in && !alloc_grant_out && !alloc_refused_out;
  // refused before the lists exist or with nothing left to give
  assign alloc_ok = lists_ready_out && free_count != `COUNT_RESET;

  // ***************************************************************
  // bank and address of buffers
  // ***************************************************************
  logic release_odd;
  logic [`SRAM_ADDR_WIDTH-1:0] pop_sram_addr;

  // a released buffer is filed by where it really starts
  buffer_locate rel_loc (
    .id_in(release_id_in),
    .memory_type_in(memory_type_select_in),
    .sram_addr_out(),
    .odd_bank_out(release_odd)
  );

  buffer_locate pop_loc (
    .id_in(pop_id),
    .memory_type_in(memory_type_select_in),
    .sram_addr_out(pop_sram_addr),
    .odd_bank_out()
  );

  // ids that follow a never-linked head, one of which is the next
  // buffer of the same bank
  free_list_pkg::buf_id_t cand [0:`FRESH_SPAN-1];
  logic [`FRESH_SPAN-1:0] cand_odd;

  genvar k;
  generate
    for (k = 0; k < `FRESH_SPAN; k = k + 1) begin : g_cand
      assign cand[k] = pop_id + `ID_WIDTH'(k + 1);
      buffer_locate cand_loc (
        .id_in(cand[k]),
        .memory_type_in(memory_type_select_in),
        .sram_addr_out(),
        .odd_bank_out(cand_odd[k])
      );
    end
  endgenerate

  // ***************************************************************
  // next head after a pop
  // ***************************************************************
  free_list_pkg::buf_id_t next_head;

  always_comb begin
    next_head = cand[`FRESH_SPAN-1];
    if (lm.rd_data.epoch == epoch) begin
      next_head = lm.rd_data.next;
    end else begin
      // an id never linked since the clear: walk forward in its bank
      for (int i = `FRESH_SPAN - 1; i >= 0; i--) begin
        if (cand_odd[i] == pop_bank) begin
          next_head = cand[i];
        end
      end
    end
  end

  // ***************************************************************
  // link memory access
  // ***************************************************************
  // release pushes the buffer in front of its bank's list
  always_comb begin
    lm.wr_en = take_release;
    lm.wr_addr = release_id_in;
    lm.wr_data.epoch = epoch;
    lm.wr_data.next = head[release_odd];
    lm.rd_en = take_alloc && alloc_ok;
    lm.rd_addr = head[alloc_bank_in];
  end

  // ***************************************************************
  // pop sequencer
  // ***************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= free_list_pkg::ST_IDLE;
      pop_bank <= 1'b0;
      pop_id <= `HEAD_RESET;
    end else begin
      unique case (state)
        free_list_pkg::ST_IDLE: begin
          if (take_alloc && alloc_ok) begin
            state <= free_list_pkg::ST_POP_WAIT;
            pop_bank <= alloc_bank_in;
            pop_id <= head[alloc_bank_in];
          end
        end
        free_list_pkg::ST_POP_WAIT: begin
          state <= free_list_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // free heads
  // ***************************************************************
  // the clear command loads both heads; pops and releases load one head each
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      head[0] <= `HEAD_RESET;
      head[1] <= `HEAD_RESET;
    end else if (wr_clear) begin
      head[0] <= `BANK0_FIRST_ID;
      head[1] <= (memory_type_select_in == 1'b1) ?
        `BANK1_FIRST_ID_64M : `BANK1_FIRST_ID_16M;
    end else if (state == free_list_pkg::ST_POP_WAIT) begin
      head[pop_bank] <= next_head;
    end else if (take_release) begin
      head[release_odd] <= release_id_in;
    end
  end

  // clear generation: old links die without wiping the memory;
  // a word survives aliasing only after sixteen clears unrewritten
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      epoch <= '0;
      lists_ready_out <= 1'b0;
    end else if (wr_clear) begin
      epoch <= epoch + `EPOCH_WIDTH'(1);
      lists_ready_out <= 1'b1;
    end
  end

  // ***************************************************************
  // allocation and release answers
  // ***************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      alloc_grant_out <= 1'b0;
      alloc_refused_out <= 1'b0;
      alloc_id_out <= `HEAD_RESET;
      alloc_sram_addr_out <= '0;
      release_ack_out <= 1'b0;
    end else begin
      alloc_grant_out <= state == free_list_pkg::ST_POP_WAIT && !wr_clear;
      alloc_refused_out <= (take_alloc && !alloc_ok) ||
        (state == free_list_pkg::ST_POP_WAIT && wr_clear);
      release_ack_out <= take_release;
      if (state == free_list_pkg::ST_POP_WAIT) begin
        alloc_id_out <= pop_id;
        alloc_sram_addr_out <= pop_sram_addr;
      end
    end
  end

  // ***************************************************************
  // free block count
  // ***************************************************************
  // host byte writes win over the running count; software is the
  // one to keep the value within the sdram size
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      free_count <= `COUNT_RESET;
    end else if (wr_count_lo) begin
      free_count[7:0] <= host_data_bus_in;
    end else if (wr_count_mid) begin
      free_count[15:8] <= host_data_bus_in;
    end else if (wr_count_hi) begin
      free_count[`COUNT_TOP_BIT:16] <= host_data_bus_in[2:0];
    end else if (state == free_list_pkg::ST_POP_WAIT && !wr_clear) begin
      free_count <= free_count - `ID_WIDTH'(1);
    end else if (take_release) begin
      free_count <= free_count + `ID_WIDTH'(1);
    end
  end

  // snapshot so the later byte reads agree with the first one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      locked_count <= `COUNT_RESET;
    end else if (rd_count_lo) begin
      locked_count <= free_count;
    end
  end

  // ***************************************************************
  // host read data
  // ***************************************************************
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    unique case (host_addr_in)
      `REG_BASE + `BANK0_HEAD_OFS: next_rd_data = head[0][7:0];
      `REG_BASE + `BANK0_HEAD_OFS + 16'h0001:
        next_rd_data = head[0][15:8];
      `REG_BASE + `BANK0_HEAD_OFS + 16'h0002:
        next_rd_data = {5'h00, head[0][`ID_WIDTH-1:16]};
      `REG_BASE + `BANK1_HEAD_OFS: next_rd_data = head[1][7:0];
      `REG_BASE + `BANK1_HEAD_OFS + 16'h0001:
        next_rd_data = head[1][15:8];
      `REG_BASE + `BANK1_HEAD_OFS + 16'h0002:
        next_rd_data = {5'h00, head[1][`ID_WIDTH-1:16]};
      `REG_BASE + `FREE_COUNT_OFS:
        next_rd_data = free_count[7:0];
      `REG_BASE + `FREE_COUNT_OFS + 16'h0001:
        next_rd_data = free_count[15:8];
      `REG_BASE + `FREE_COUNT_OFS + 16'h0002:
        next_rd_data = {5'h00, free_count[`COUNT_TOP_BIT:16]};
      `LOCKED_COUNT_MID_ADDR:
        next_rd_data = locked_count[15:8];
      `LOCKED_COUNT_TOP_ADDR:
        next_rd_data = {6'h00, locked_count[17:16]};
      `LOCKED_COUNT_HI_ADDR:
        next_rd_data = {locked_count[`COUNT_TOP_BIT], 7'h00};
      default: next_rd_data = 8'h00;
    endcase
  end

  // read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      host_data_bus_out <= 8'h00;
      host_rd_valid_out <= 1'b0;
    end else begin
      host_rd_valid_out <= host_rd_in;
      if (host_rd_in) begin
        host_data_bus_out <= next_rd_data;
      end
    end
  end

endmodule : free_list_ctrl

`default_nettype wire

// File: rtl/buf_free_map.svh
// register map, reset values and fixed figures of the buffer free-list block
`ifndef BUF_FREE_MAP_SVH
`define BUF_FREE_MAP_SVH

// ***************************************************************
// register addresses
// ***************************************************************
`define REG_BASE 16'h1000
`define BANK0_HEAD_OFS 16'h0000
`define BANK1_HEAD_OFS 16'h0003
`define FREE_COUNT_OFS 16'h0006
`define CLEAR_PTRS_OFS 16'h0009
`define LOCKED_COUNT_HI_ADDR 16'h0c51
`define LOCKED_COUNT_MID_ADDR 16'h0c52
`define LOCKED_COUNT_TOP_ADDR 16'h0c53

// ***************************************************************
// field layout of the multi-byte registers
// ***************************************************************
`define ID_WIDTH 19
`define SRAM_ADDR_WIDTH 21
`define EPOCH_WIDTH 4
`define COUNT_TOP_BIT 18

// ***************************************************************
// reset and load values
// ***************************************************************
`define HEAD_RESET 19'h00000
`define COUNT_RESET 19'h00000
`define BANK0_FIRST_ID 19'h00080
`define BANK1_FIRST_ID_16M 19'h00082
`define BANK1_FIRST_ID_64M 19'h00083

// ***************************************************************
// buffer geometry
// ***************************************************************
`define BUF_BYTES 32'h00000600
`define PAGE_BYTES_16M 32'h00000800
`define PAGE_BYTES_64M 32'h00001000
`define SRAM_WORDS_PER_ID 21'h000003
`define FRESH_SPAN 4

`endif

// File: rtl/free_list_pkg.sv
// types shared by the buffer free-list modules
`include "buf_free_map.svh"

package free_list_pkg;

  typedef enum logic {MEM_16MBIT, MEM_64MBIT} memory_type_t;

  typedef enum logic {ST_IDLE, ST_POP_WAIT} pop_state_t;

  typedef logic [`ID_WIDTH-1:0] buf_id_t;

  // one link word: clear generation tag and the next buffer in the list
  typedef struct packed {
    logic [`EPOCH_WIDTH-1:0] epoch;
    buf_id_t next;
  } link_word_t;

endpackage : free_list_pkg

// File: rtl/link_mem_if.sv
// port bundle between the list controller and its link memory
`timescale 1ns/1ps
`default_nettype none

interface link_mem_if;
  logic rd_en;
  free_list_pkg::buf_id_t rd_addr;
  free_list_pkg::link_word_t rd_data;
  logic wr_en;
  free_list_pkg::buf_id_t wr_addr;
  free_list_pkg::link_word_t wr_data;

  modport owner (
    output rd_en, rd_addr, wr_en, wr_addr, wr_data,
    input rd_data
  );
  modport mem (
    input rd_en, rd_addr, wr_en, wr_addr, wr_data,
    output rd_data
  );
endinterface : link_mem_if

`default_nettype wire

// File: rtl/link_mem.sv
// link memory: next-buffer word per buffer id, registered read
`timescale 1ns/1ps
`default_nettype none
`include "buf_free_map.svh"

module link_mem (
  // clock
  input wire logic clk_in,
  // access port
  link_mem_if.mem port
);

  free_list_pkg::link_word_t store [0:(1<<`ID_WIDTH)-1];

  // no reset on the array: stale words are told apart by their epoch
  always_ff @(posedge clk_in) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // read data always comes out of a register
  always_ff @(posedge clk_in) begin
    if (port.rd_en) begin
      port.rd_data <= store[port.rd_addr];
    end
  end

endmodule : link_mem

`default_nettype wire

// File: rtl/buffer_locate.sv
// maps a buffer id to its sram word address and its sdram bank
`timescale 1ns/1ps
`default_nettype none
`include "buf_free_map.svh"

module buffer_locate (
  // buffer and memory type
  input wire logic [`ID_WIDTH-1:0] id_in,
  input wire logic memory_type_in,
  // location
  output logic [`SRAM_ADDR_WIDTH-1:0] sram_addr_out,
  output logic odd_bank_out
);

  logic [31:0] byte_addr;
  logic [31:0] page_idx;

  // fixed 1536-byte buffers: start byte is id times buffer size
  assign byte_addr = {13'h0000, id_in} * `BUF_BYTES;
  // page parity picks the bank; page size follows the part size
  assign page_idx = (memory_type_in == 1'b1) ?
    (byte_addr / `PAGE_BYTES_64M) : (byte_addr / `PAGE_BYTES_16M);
  assign odd_bank_out = page_idx[0];
  // the pointer is an id; the sram word address is three per id
  assign sram_addr_out = {2'b00, id_in} * `SRAM_WORDS_PER_ID;

endmodule : buffer_locate

`default_nettype wire

// File: bench/free_list_checker.sv
// port assertions for the buffer free-list controller
`timescale 1ns/1ps
`default_nettype none
`include "buf_free_map.svh"

module free_list_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // host bus
  input wire logic [15:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_rd_valid_out,
  // allocation side
  input wire logic alloc_grant_out,
  input wire logic alloc_refused_out,
  input wire logic [`ID_WIDTH-1:0] alloc_id_out,
  input wire logic [`SRAM_ADDR_WIDTH-1:0] alloc_sram_addr_out,
  input wire logic lists_ready_out
);
  // ****
  // one clock domain, so one default clock and disable
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rd_answer;
    host_rd_in |=> host_rd_valid_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read strobe got no answer");
  property p_rd_idle;
    !host_rd_in |=> !host_rd_valid_out && $stable(host_data_bus_out);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data moved without a read");
  property p_top_lanes;
    host_rd_in && host_addr_in == `LOCKED_COUNT_TOP_ADDR
      |=> host_data_bus_out[7:2] == 6'h00;
  endproperty
  a_top_lanes: assert property (p_top_lanes)
    else $error("unused lanes of locked top byte not zero");
  property p_hi_lanes;
    host_rd_in && host_addr_in == `LOCKED_COUNT_HI_ADDR
      |=> host_data_bus_out[6:0] == 7'h00;
  endproperty
  a_hi_lanes: assert property (p_hi_lanes)
    else $error("unused lanes of locked high byte not zero");
  property p_clear_rd;
    host_rd_in && host_addr_in == `REG_BASE + `CLEAR_PTRS_OFS
      |=> host_data_bus_out == 8'h00;
  endproperty
  a_clear_rd: assert property (p_clear_rd)
    else $error("clear command address read back non zero");
  property p_ready;
    host_wr_in && host_addr_in == `REG_BASE + `CLEAR_PTRS_OFS
      |=> lists_ready_out ##1 lists_ready_out;
  endproperty
  a_ready: assert property (p_ready)
    else $error("clear command did not make lists ready");
  property p_no_grant;
    !lists_ready_out |=> !alloc_grant_out;
  endproperty
  a_no_grant: assert property (p_no_grant)
    else $error("grant before any clear command");
  property p_sram_addr;
    alloc_grant_out |-> alloc_sram_addr_out == alloc_id_out * 3
      ##1 !alloc_grant_out && !alloc_refused_out;
  endproperty
  a_sram_addr: assert property (p_sram_addr)
    else $error("granted sram address is not id times three");
endmodule : free_list_checker

bind free_list_ctrl free_list_checker chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .host_addr_in(host_addr_in),
  .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
  .host_data_bus_out(host_data_bus_out),
  .host_rd_valid_out(host_rd_valid_out),
  .alloc_grant_out(alloc_grant_out), .alloc_refused_out(alloc_refused_out),
  .alloc_id_out(alloc_id_out), .alloc_sram_addr_out(alloc_sram_addr_out),
  .lists_ready_out(lists_ready_out)
);

`default_nettype wire

// File: bench/host_cpu_model.sv
// host processor model on the byte-wide register bus
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model (
  // clock
  input wire logic clk_in,
  // bus towards the device
  output logic [15:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  // answer from the device
  input wire logic [7:0] rdata_in,
  input wire logic rd_valid_in
);
  // idle bus at time zero
  initial begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // one byte write; released lines flip so stale values never match
  task automatic wr1(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr1
  // one byte read; no valid pulse gives unknown data to the caller
  task automatic rd1(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = (rd_valid_in === 1'b1) ? rdata_in : 8'hxx;
  endtask : rd1
  // three byte write, low byte first
  task automatic wr3(input logic [15:0] base, input logic [18:0] v);
    wr1(base, v[7:0]);
    wr1(base + 16'h0001, v[15:8]);
    wr1(base + 16'h0002, {5'h00, v[18:16]});
  endtask : wr3
  // three byte live read, top byte carries bits 18..16
  task automatic rd3(input logic [15:0] base, output logic [18:0] v);
    logic [7:0] b0, b1, b2;
    rd1(base, b0);
    rd1(base + 16'h0001, b1);
    rd1(base + 16'h0002, b2);
    v = {b2[2:0], b1, b0};
  endtask : rd3
endmodule : host_cpu_model

`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the buffer free-list controller
`timescale 1ns/1ps
`default_nettype none
`include "buf_free_map.svh"

module tb;
  // ****
  // clock, stimulus and hookup
  // ****
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] host_addr;
  logic host_wr, host_rd, rd_valid, grant, refused, rel_ack, ready;
  logic [7:0] wdata, rdata;
  logic mem_type = 1'b0;
  logic alloc_req = 1'b0;
  logic alloc_bank = 1'b0;
  logic rel_req = 1'b0;
  logic [`ID_WIDTH-1:0] alloc_id, rel_id = '0;
  logic [`SRAM_ADDR_WIDTH-1:0] sram_addr;
  int failures = 0;
  int n_tests = 0;
  always #2.5 clk_in = ~clk_in;
  host_cpu_model host_u (.clk_in(clk_in), .addr_out(host_addr),
    .wr_out(host_wr), .rd_out(host_rd), .wdata_out(wdata),
    .rdata_in(rdata), .rd_valid_in(rd_valid));
  free_list_ctrl dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .host_addr_in(host_addr), .host_wr_in(host_wr), .host_rd_in(host_rd),
    .host_data_bus_in(wdata), .host_data_bus_out(rdata),
    .host_rd_valid_out(rd_valid), .memory_type_select_in(mem_type),
    .alloc_req_in(alloc_req), .alloc_bank_in(alloc_bank),
    .alloc_grant_out(grant), .alloc_refused_out(refused),
    .alloc_id_out(alloc_id), .alloc_sram_addr_out(sram_addr),
    .release_req_in(rel_req), .release_id_in(rel_id),
    .release_ack_out(rel_ack), .lists_ready_out(ready));
  // compare and count
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // bank of a buffer: parity of the sdram page it starts in
  function automatic logic bank_of(input logic [18:0] id, input logic t);
    logic [31:0] page;
    page = (32'(id) * 32'd1536) / (t ? 32'd4096 : 32'd2048);
    return page[0];
  endfunction : bank_of
  // pop request held until grant or refusal, bounded wait
  task automatic alloc(input logic b, output logic g);
    int i;
    @(posedge clk_in);
    #1;
    alloc_bank = b;
    alloc_req = 1'b1;
    for (i = 0; i < 8 && grant !== 1'b1 && refused !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    g = grant;
    alloc_req = 1'b0;
    alloc_bank = ~b;
    if (i == 8) begin
      failures++;
      report_and_stop();
    end
  endtask : alloc
  // release request held until acknowledged, bounded wait
  task automatic rel(input logic [18:0] id);
    int i;
    @(posedge clk_in);
    #1;
    rel_id = id;
    rel_req = 1'b1;
    for (i = 0; i < 8 && rel_ack !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    rel_req = 1'b0;
    rel_id = ~id;
    if (i == 8) begin
      failures++;
      report_and_stop();
    end
  endtask : rel
  // ****
  // test sequence
  // ****
  initial begin
    logic [18:0] v;
    logic [7:0] b;
    logic g;
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    // registers clear after reset, lists unusable before a clear
    // nine register bytes and the clear command address all read zero
    for (int a = 0; a < 10; a++) begin
      host_u.rd1(16'(32'h1000 + a), b);
      check("reset byte", 32'h0, b);
    end
    check("ready before clear", 32'h0, ready);
    alloc(1'b0, g);
    check("grant before clear", 32'h0, g);
    check("refused before clear", 32'h1, refused);
    $display("test reset done");
    // clear under each memory type; heads ignore host writes
    for (int t = 0; t < 2; t++) begin
      mem_type = t[0];
      host_u.wr1(16'h1009, 8'h00);
      check("lists ready", 32'h1, ready);
      host_u.rd3(16'h1000, v);
      check("bank0 head", 32'd128, v);
      host_u.rd3(16'h1003, v);
      check("bank1 head", t ? 32'd131 : 32'd130, v);
      host_u.wr1(16'h1003, 8'h55);
      host_u.rd3(16'h1003, v);
      check("bank1 head kept", t ? 32'd131 : 32'd130, v);
    end
    $display("test clear done");
    // the pop borrows across bytes, so live and locked bytes differ
    host_u.wr3(16'h1006, 19'h5a500);
    host_u.rd1(16'h1008, b);
    check("live count top", 32'h05, b);
    host_u.rd1(16'h1006, b);
    check("count low", 32'h00, b);
    alloc(1'b0, g);
    check("grant", 32'h1, g);
    check("granted id", 32'd128, alloc_id);
    check("granted sram addr", 32'd384, sram_addr);
    host_u.rd1(16'h0c52, b);
    check("locked mid", 32'ha5, b);
    host_u.rd1(16'h0c53, b);
    check("locked top", 32'h01, b);
    host_u.rd1(16'h0c51, b);
    check("locked high", 32'h80, b);
    host_u.rd3(16'h1006, v);
    check("count after pop", 32'h5a4ff, v);
    host_u.rd3(16'h1000, v);
    check("bank0 next", 32'd129, v);
    $display("test lock done");
    // releases land on their own bank list, count follows
    host_u.wr3(16'h1006, 19'h01555);
    // 130 starts in an even page and 133 in an odd one (64 Mbit)
    for (int k = 130; k < 134; k += 3) begin
      rel(19'(k));
      host_u.rd3(bank_of(19'(k), 1'b1) ? 16'h1003 : 16'h1000, v);
      check("released head", k, v);
    end
    host_u.rd3(16'h1006, v);
    check("count after release", 32'h01557, v);
    alloc(1'b1, g);
    check("bank1 pop id", 32'd133, alloc_id);
    host_u.rd3(16'h1003, v);
    check("bank1 next", 32'd131, v);
    $display("test release done");
    // clear lands in the second cycle of a pop: refused, heads reload
    fork
      alloc(1'b0, g);
      begin
        @(posedge clk_in);
        host_u.wr1(16'h1009, 8'h00);
      end
    join
    check("grant under clear", 32'h0, g);
    check("refused under clear", 32'h1, refused);
    host_u.rd3(16'h1000, v);
    check("bank0 head reloaded", 32'd128, v);
    host_u.rd3(16'h1006, v);
    check("count kept", 32'h01556, v);
    host_u.wr3(16'h1006, 19'h00000);
    alloc(1'b0, g);
    check("grant on empty count", 32'h0, g);
    check("refused on empty count", 32'h1, refused);
    $display("test clear during pop done");
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
